//--- logic/pdm_ctrl.sv
/*
  Power-down mode controller with an AXI4-Lite register slave.
  Assumes the CPU halts while cpu_halt is high, the wake sources are single
  synchronous levels or pulses, and reset of the rest of the chip is external.
  Registers sit at byte address four times their index; address bits 1:0 are
  ignored, so every register is one aligned 32-bit word.
*/
// The AXI4-Lite register port was decided locally.
// Overview of operation
// - Writing 01 enters idle, CPU halted
// - Idle ends on reset or enabled interrupt
// - Reset returns every register to default
// - Writing 03 enters stop, main clocks halted
// - RAM and registers kept while frozen
// - CPU suspended in every power-down mode
// - Stop wake runs stabilisation timer first
// - Stop wake needs individual and global enable
// - General timers halt unless event counting
// - Watch timer stops unless sub-clock mode
// - Serial ports run only on external clock
// - Stop wake sources differ by variant
// - System clock bit 7 picks stop variant
// - Low oscillator runs only in one variant
// - Mode register clears on stop release
`timescale 1ns/100ps
`default_nettype none

module pdm_ctrl #(
  parameter int STAB_CYCLES_P = pdm_pkg::STAB_CYCLES,
  parameter int NSRC          = pdm_pkg::NUM_SRC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [9:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [9:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NSRC-1:0]   irq_req,
  input  wire logic              global_interrupt_enable,
  output logic                   cpu_halt,
  output logic                   main_clk_en,
  output logic                   periph_clk_en,
  output logic                   lowosc_en,
  output logic                   bit_wdt_run,
  output logic                   watch_timer_run,
  output logic                   timer0_run,
  output logic                   timer2_run,
  output logic                   serial_io_port_run,
  output logic                   uart_run,
  output logic                   wake_pulse,
  output logic [NSRC-1:0]        wake_src
);

  // Wide enough for the full 20 ms count at the default clock
  localparam int SW = 32;

  pdm_pkg::pdm_state_e state_r;
  logic [7:0]          power_mode_control_r;
  logic [7:0]          system_clock_control_r;
  logic [NSRC-1:0]     wake_en_r;
  logic [7:0]          periph_cfg_r;
  logic [SW-1:0]       stab_cnt_r;
  logic                aw_hold_r;
  logic                w_hold_r;
  logic [7:0]          aw_addr_r;
  logic [31:0]         w_data_r;
  logic                w_lane0_r;
  logic                wr_fire;
  logic                mode_wr;
  logic [NSRC-1:0]     stop_mask;
  logic [NSRC-1:0]     wake_hits;
  logic                stop_wake;
  logic                idle_wake;
  logic [7:0]          ar_idx;

  // Decode of an address into a known register
  // Shared by the write response and the read path
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == pdm_pkg::PWR_MODE_OFF) || (a == pdm_pkg::SYSCLK_OFF) ||
                 (a == pdm_pkg::WAKE_EN_OFF) || (a == pdm_pkg::PERIPH_OFF) ||
                 (a == pdm_pkg::STATUS_OFF);
  endfunction

  // Write fires once both address and data are held
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign mode_wr = wr_fire && w_lane0_r && (aw_addr_r == pdm_pkg::PWR_MODE_OFF);
  // Read index taken from the word address, lanes below it ignored
  assign ar_idx  = s_axi_araddr[9:2];

  // the low-osc-off variant drops watchdog and interval-timer wakes
  // stop wake needs each individual and the global enable
  always_comb begin
    stop_mask = '1;
    // Sources outside the stop release list never end a stop
    stop_mask[pdm_pkg::SRC_OTHER] = 1'b0;
    if (state_r == pdm_pkg::PDM_STOP_LO_OFF) begin
      stop_mask[pdm_pkg::SRC_WDT] = 1'b0;
      stop_mask[pdm_pkg::SRC_BIT] = 1'b0;
    end
    // watch timer only wakes in sub-clock mode
    if (!system_clock_control_r[pdm_pkg::SYSCLK_SUBCLK_BIT]) begin
      stop_mask[pdm_pkg::SRC_WT] = 1'b0;
    end
    if (!periph_cfg_r[pdm_pkg::PER_EC0_BIT]) begin
      stop_mask[pdm_pkg::SRC_EC0] = 1'b0;
    end
    if (!periph_cfg_r[pdm_pkg::PER_EC2_BIT]) begin
      stop_mask[pdm_pkg::SRC_EC2] = 1'b0;
    end
    if (!periph_cfg_r[pdm_pkg::PER_SPI_EXT_BIT]) begin
      stop_mask[pdm_pkg::SRC_SIO] = 1'b0;
    end
    if (!periph_cfg_r[pdm_pkg::PER_UART_EXT_BIT]) begin
      stop_mask[pdm_pkg::SRC_UART] = 1'b0;
    end
  end

  // idle releases on any enabled interrupt
  // Idle takes any enabled source; stop only those the mask lets through
  assign wake_hits = irq_req & wake_en_r;
  assign idle_wake = global_interrupt_enable && (|wake_hits);
  assign stop_wake = global_interrupt_enable && (|(wake_hits & stop_mask));

  // Power state sequencing
  // reset forces run and default registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= pdm_pkg::PDM_RUN;
      stab_cnt_r <= '0;
    end else begin
      unique case (state_r)
        pdm_pkg::PDM_RUN: begin
          // Other codes are only stored and leave the power state alone
          // code 01 enters idle
          if (mode_wr && w_data_r[7:0] == pdm_pkg::MODE_IDLE) begin
            state_r <= pdm_pkg::PDM_IDLE;
          // bit 7 of system clock control picks variant
          end else if (mode_wr && w_data_r[7:0] == pdm_pkg::MODE_STOP) begin
            state_r <= system_clock_control_r[pdm_pkg::SYSCLK_LOWOSC_BIT] ?
                       pdm_pkg::PDM_STOP_LO_ON : pdm_pkg::PDM_STOP_LO_OFF;
          end
        end
        pdm_pkg::PDM_IDLE: begin
          if (idle_wake) begin
            state_r <= pdm_pkg::PDM_RUN;
          end
        end
        pdm_pkg::PDM_STOP_LO_ON,
        pdm_pkg::PDM_STOP_LO_OFF: begin
          if (stop_wake) begin
            state_r    <= pdm_pkg::PDM_STAB;
            stab_cnt_r <= '0;
          end
        end
        pdm_pkg::PDM_STAB: begin
          // Counting from zero holds the CPU for exactly STAB_CYCLES_P cycles
          if (stab_cnt_r >= STAB_CYCLES_P - 1) begin
            state_r <= pdm_pkg::PDM_RUN;
          end else begin
            stab_cnt_r <= stab_cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  // Wake report towards the CPU, so it vectors to the source's handler
  // Sources stay shown until the next wake so the handler can be chosen late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_pulse <= 1'b0;
      wake_src   <= '0;
    end else begin
      wake_pulse <= 1'b0;
      // resume vectors to the waking interrupt
      if (state_r == pdm_pkg::PDM_IDLE && idle_wake) begin
        wake_pulse <= 1'b1;
        wake_src   <= wake_hits;
      end else if ((state_r == pdm_pkg::PDM_STOP_LO_ON || state_r == pdm_pkg::PDM_STOP_LO_OFF) && stop_wake) begin
        wake_src   <= wake_hits & stop_mask;
      end else if (state_r == pdm_pkg::PDM_STAB && stab_cnt_r >= STAB_CYCLES_P - 1) begin
        wake_pulse <= 1'b1;
      end
    end
  end

  // Clock and peripheral gating per state
  // All gates lag the state by one cycle, so halt and clocks switch together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_halt           <= 1'b0;
      main_clk_en        <= 1'b1;
      periph_clk_en      <= 1'b1;
      lowosc_en          <= 1'b1;
      bit_wdt_run        <= 1'b1;
      watch_timer_run    <= 1'b1;
      timer0_run         <= 1'b1;
      timer2_run         <= 1'b1;
      serial_io_port_run <= 1'b1;
      uart_run           <= 1'b1;
    end else begin
      // CPU halted in idle, stop and stabilisation
      cpu_halt <= (state_r != pdm_pkg::PDM_RUN);
      // main and peripheral clocks off in stop
      main_clk_en   <= (state_r == pdm_pkg::PDM_RUN) || (state_r == pdm_pkg::PDM_IDLE);
      periph_clk_en <= (state_r == pdm_pkg::PDM_RUN) || (state_r == pdm_pkg::PDM_IDLE);
      // low oscillator stops only in low-osc-off stop
      lowosc_en <= (state_r != pdm_pkg::PDM_STOP_LO_OFF);
      // interval timer and watchdog stop only in low-osc-off stop
      bit_wdt_run <= (state_r != pdm_pkg::PDM_STOP_LO_OFF);
      if (state_r == pdm_pkg::PDM_STOP_LO_ON || state_r == pdm_pkg::PDM_STOP_LO_OFF) begin
        watch_timer_run    <= system_clock_control_r[pdm_pkg::SYSCLK_SUBCLK_BIT];
        timer0_run         <= periph_cfg_r[pdm_pkg::PER_EC0_BIT];
        timer2_run         <= periph_cfg_r[pdm_pkg::PER_EC2_BIT];
        // serial ports only on external clock
        serial_io_port_run <= periph_cfg_r[pdm_pkg::PER_SPI_EXT_BIT];
        uart_run           <= periph_cfg_r[pdm_pkg::PER_UART_EXT_BIT];
      end else begin
        watch_timer_run    <= 1'b1;
        timer0_run         <= 1'b1;
        timer2_run         <= 1'b1;
        serial_io_port_run <= 1'b1;
        uart_run           <= 1'b1;
      end
    end
  end

  // Register file; contents change only by writes and the wake clear of the mode register, so frozen state holds
  // registers retained through power-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_mode_control_r   <= pdm_pkg::PWR_MODE_RST;
      system_clock_control_r <= pdm_pkg::SYSCLK_RST;
      wake_en_r              <= '0;
      periph_cfg_r           <= '0;
    end else begin
      if (wr_fire && w_lane0_r) begin
        unique case (aw_addr_r)
          pdm_pkg::PWR_MODE_OFF: power_mode_control_r   <= w_data_r[7:0];
          pdm_pkg::SYSCLK_OFF:   system_clock_control_r <= w_data_r[7:0];
          pdm_pkg::PERIPH_OFF:   periph_cfg_r           <= w_data_r[7:0];
          default: ;
        endcase
      end
      if (wr_fire && aw_addr_r == pdm_pkg::WAKE_EN_OFF) begin
        wake_en_r <= w_data_r[NSRC-1:0];
      end
      // A wake beats a same-cycle bus write, leaving the mode register clear
      // stop release clears the mode register
      if ((state_r == pdm_pkg::PDM_STOP_LO_ON || state_r == pdm_pkg::PDM_STOP_LO_OFF) && stop_wake) begin
        power_mode_control_r <= pdm_pkg::MODE_RUN;
      end else if (state_r == pdm_pkg::PDM_IDLE && idle_wake) begin
        power_mode_control_r <= pdm_pkg::MODE_RUN;
      end
    end
  end

  // AXI write channels: address and data accepted in either order
  // Ready pulses once per beat; new beats wait until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_lane0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pdm_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[9:2];  // Word index
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_known(aw_addr_r) && aw_addr_r != pdm_pkg::STATUS_OFF) ?
                        pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
    end
  end

  // AXI read channel; status shows the controller state
  // A new read waits while read data are still offered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pdm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_known(ar_idx) ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
        // Unmapped indices read as zero
        unique case (ar_idx)
          pdm_pkg::PWR_MODE_OFF: s_axi_rdata <= {24'h000000, power_mode_control_r};
          pdm_pkg::SYSCLK_OFF:   s_axi_rdata <= {24'h000000, system_clock_control_r};
          pdm_pkg::WAKE_EN_OFF:  s_axi_rdata <= {{(32-NSRC){1'b0}}, wake_en_r};
          pdm_pkg::PERIPH_OFF:   s_axi_rdata <= {24'h000000, periph_cfg_r};
          pdm_pkg::STATUS_OFF:   s_axi_rdata <= {29'h0, state_r};
          default:               s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- logic/pdm_pkg.sv
/*
  Package for the power-down mode controller: register offsets, mode codes,
  reset values and timing counts.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package pdm_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] PWR_MODE_OFF  = 8'h87;  // Index of the mode register
  localparam logic [7:0] SYSCLK_OFF    = 8'h88;
  localparam logic [7:0] WAKE_EN_OFF   = 8'h89;
  localparam logic [7:0] PERIPH_OFF    = 8'h8a;
  localparam logic [7:0] STATUS_OFF    = 8'h8b;
  localparam logic [7:0] STAB_DIV_OFF  = 8'h8c;

  // Power mode control codes and register reset values
  localparam logic [7:0] MODE_RUN      = 8'h00;
  localparam logic [7:0] MODE_IDLE     = 8'h01;
  localparam logic [7:0] MODE_STOP     = 8'h03;
  localparam logic [7:0] PWR_MODE_RST  = 8'h00;
  localparam logic [7:0] SYSCLK_RST    = 8'h00;
  localparam logic [7:0] STAB_DIV_RST  = 8'h00;

  // Field positions
  localparam int SYSCLK_LOWOSC_BIT = 7;  // One selects the low-osc-on stop
  localparam int SYSCLK_SUBCLK_BIT = 0;  // Sub-clock mode for the watch timer
  localparam int PER_EC0_BIT       = 0;  // Timer 0 in event-counter mode
  localparam int PER_EC2_BIT       = 1;  // Timer 2 in event-counter mode
  localparam int PER_SPI_EXT_BIT   = 2;  // Serial port on external clock
  localparam int PER_UART_EXT_BIT  = 3;  // Async port on external clock

  // Wake source indices
  localparam int NUM_SRC   = 10;
  localparam int SRC_EC0   = 0;
  localparam int SRC_EC2   = 1;
  localparam int SRC_SIO   = 2;
  localparam int SRC_EXT   = 3;
  localparam int SRC_UART  = 4;
  localparam int SRC_I2CS  = 5;
  localparam int SRC_WT    = 6;
  localparam int SRC_WDT   = 7;
  localparam int SRC_BIT   = 8;
  localparam int SRC_OTHER = 9;

  // Oscillator stabilisation: at least 20 ms
  localparam int STAB_MS      = 20;
  localparam int CLK_HZ       = 10_000_000;
  localparam int STAB_CYCLES  = (STAB_MS * (CLK_HZ / 1000));

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PDM_RUN,
    PDM_IDLE,
    PDM_STOP_LO_ON,
    PDM_STOP_LO_OFF,
    PDM_STAB
  } pdm_state_e;

endpackage

//--- verif/pdm_ctrl_sva.sv
/*
  Port checker for the power-down mode controller.
  Assumes it is bound to pdm_ctrl and that aclk is the only clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pdm_ctrl_sva #(
  parameter int STAB_CYCLES_P = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [9:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        global_interrupt_enable,
  input wire logic        cpu_halt,
  input wire logic        main_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        lowosc_en,
  input wire logic        bit_wdt_run,
  input wire logic        watch_timer_run,
  input wire logic        timer0_run,
  input wire logic        timer2_run,
  input wire logic        serial_io_port_run,
  input wire logic        uart_run
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  int lo_cnt_r;

  // Length of the current main-clock gap, so a short wake can be caught
  always_ff @(posedge aclk) begin
    if (!aresetn || main_clk_en) begin
      lo_cnt_r <= 0;
    end else begin
      lo_cnt_r <= lo_cnt_r + 1;
    end
  end

  property p_idle_entry; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] &&
    s_axi_awaddr[9:2] == pdm_pkg::PWR_MODE_OFF && s_axi_wdata[7:0] == pdm_pkg::MODE_IDLE && !cpu_halt
    |-> ##[1:6] cpu_halt;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle write did not halt the cpu");
  property p_halt_gated; !main_clk_en |-> cpu_halt; endproperty
  a_halt_gated: assert property (p_halt_gated) else $error("cpu running without main clock");
  property p_periph_main; periph_clk_en == main_clk_en; endproperty
  a_periph_main: assert property (p_periph_main) else $error("peripheral clock differs from main clock");
  property p_bit_wdt; bit_wdt_run == lowosc_en; endproperty
  a_bit_wdt: assert property (p_bit_wdt) else $error("interval timer not tied to low oscillator");
  property p_lowosc_stop; !lowosc_en |-> !main_clk_en && cpu_halt; endproperty
  a_lowosc_stop: assert property (p_lowosc_stop) else $error("low oscillator off outside stop");
  property p_run_all; main_clk_en |-> timer0_run && timer2_run && watch_timer_run && serial_io_port_run && uart_run;
  endproperty
  a_run_all: assert property (p_run_all) else $error("peripheral stopped while clocks run");
  // Clocks coming back on through reset are not a stop wake
  property p_stab_len; $rose(main_clk_en) && $past(aresetn) |-> lo_cnt_r >= STAB_CYCLES_P; endproperty
  a_stab_len: assert property (p_stab_len) else $error("stop wake shorter than stabilisation");
  property p_no_gie; cpu_halt && main_clk_en && !global_interrupt_enable && !$past(global_interrupt_enable) &&
    !$past(global_interrupt_enable, 2) |=> cpu_halt; endproperty
  a_no_gie: assert property (p_no_gie) else $error("idle left without global enable");
endmodule

bind pdm_ctrl pdm_ctrl_sva #(.STAB_CYCLES_P(STAB_CYCLES_P)) i_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .global_interrupt_enable(global_interrupt_enable),
  .cpu_halt(cpu_halt), .main_clk_en(main_clk_en), .periph_clk_en(periph_clk_en), .lowosc_en(lowosc_en),
  .bit_wdt_run(bit_wdt_run), .watch_timer_run(watch_timer_run), .timer0_run(timer0_run),
  .timer2_run(timer2_run), .serial_io_port_run(serial_io_port_run), .uart_run(uart_run)
);

`default_nettype wire

//--- verif/pdm_cpu_model.sv
/*
  Model of the CPU core and the interrupt sources around the controller.
  Assumes the bench pulses raise for one cycle per request.
*/
`timescale 1ns/100ps
`default_nettype none

module pdm_cpu_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [9:0] raise,
  input  wire logic       gie_set,
  input  wire logic       cpu_halt,
  output logic      [9:0] irq_req,
  output logic            global_interrupt_enable
);
  logic halt_q_r;

  // global enable follows the bench's gie_set one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_interrupt_enable <= 1'b0;
    end else begin
      global_interrupt_enable <= gie_set;
    end
  end

  // requests stay pending until the CPU resumes and vectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req  <= 10'h000;
      halt_q_r <= 1'b0;
    end else begin
      halt_q_r <= cpu_halt;
      if (halt_q_r && !cpu_halt) begin
        irq_req <= raise;
      end else begin
        irq_req <= irq_req | raise;
      end
    end
  end
endmodule

`default_nettype wire

//--- verif/tb_power_down_mode_control.sv
/*
  Self-checking bench for the power-down mode controller.
  Assumes pdm_ctrl with a short stabilisation count and the CPU model beside it.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_power_down_mode_control;
  localparam int STAB = 8;
  logic        aclk, aresetn, gie_set, global_interrupt_enable, cpu_halt, wake_pulse, pulse_seen;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        main_clk_en, periph_clk_en, lowosc_en, bit_wdt_run, watch_timer_run;
  logic        timer0_run, timer2_run, serial_io_port_run, uart_run;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  irq_req, wake_src, raise, gates;
  int          n_errors, n_compared, n_cyc;

  assign gates = {main_clk_en, periph_clk_en, lowosc_en, bit_wdt_run, watch_timer_run, timer0_run,
                  timer2_run, serial_io_port_run, uart_run, cpu_halt};

  // Short stabilisation count keeps the stop wake quick in simulation
  pdm_ctrl #(.STAB_CYCLES_P(STAB)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_req, .global_interrupt_enable, .cpu_halt, .main_clk_en, .periph_clk_en, .lowosc_en, .bit_wdt_run,
    .watch_timer_run, .timer0_run, .timer2_run, .serial_io_port_run, .uart_run, .wake_pulse, .wake_src);
  pdm_cpu_model i_cpu (.aclk, .aresetn, .raise, .gie_set, .cpu_halt, .irq_req, .global_interrupt_enable);

  // Clock at 10 MHz
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped at its own ready; a is the index
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= {a, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic irq(input logic [9:0] m);
    @(posedge aclk);
    raise <= m;
    @(posedge aclk);
    raise <= 10'h000;
  endtask

  // Bounded wait for the CPU to resume, noting the wake pulse on the way
  task automatic wake();
    n_cyc = 0;
    pulse_seen = 1'b0;
    do begin
      @(posedge aclk);
      n_cyc++;
      if (wake_pulse === 1'b1) pulse_seen = 1'b1;
    end while (cpu_halt !== 1'b0 && n_cyc < 500);
    repeat (2) @(posedge aclk) if (wake_pulse === 1'b1) pulse_seen = 1'b1;
    chk("resume", {31'h0, cpu_halt}, 32'h0);
  endtask

  // Hang guard, far beyond the length of the sequence
  initial begin
    #3_000_000;
    n_errors++;
    stop_test();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, gie_set} <= 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 52'h0;
    s_axi_wstrb <= 4'hf;
    raise       <= 10'h000;
    aresetn     <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Defaults, an unmapped place and the read-only status
    for (int i = 8'h87; i <= 8'h8b; i++) rd(i[7:0], 32'h0, pdm_pkg::RESP_OKAY);
    rd(8'h90, 32'h0, pdm_pkg::RESP_SLVERR);
    wr(pdm_pkg::STATUS_OFF, 32'h1, pdm_pkg::RESP_SLVERR);
    wr(pdm_pkg::WAKE_EN_OFF, 32'h3ff, pdm_pkg::RESP_OKAY);
    // Idle: held by a missing global enable, then woken
    wr(pdm_pkg::PWR_MODE_OFF, 32'h01, pdm_pkg::RESP_OKAY);
    rd(pdm_pkg::STATUS_OFF, {29'h0, pdm_pkg::PDM_IDLE}, pdm_pkg::RESP_OKAY);
    chk("gates", {22'h0, gates}, 32'h3ff);
    irq(10'h008);
    repeat (6) @(posedge aclk);
    rd(pdm_pkg::STATUS_OFF, {29'h0, pdm_pkg::PDM_IDLE}, pdm_pkg::RESP_OKAY);
    gie_set <= 1'b1;
    wake();
    chk("wake_src", {22'h0, wake_src}, 32'h008);
    rd(pdm_pkg::PWR_MODE_OFF, 32'h0, pdm_pkg::RESP_OKAY);
    // Stop with low oscillator on, nothing configured to keep running
    wr(pdm_pkg::SYSCLK_OFF, 32'h80, pdm_pkg::RESP_OKAY);
    wr(pdm_pkg::PWR_MODE_OFF, 32'h03, pdm_pkg::RESP_OKAY);
    rd(pdm_pkg::STATUS_OFF, {29'h0, pdm_pkg::PDM_STOP_LO_ON}, pdm_pkg::RESP_OKAY);
    chk("gates", {22'h0, gates}, 32'h0c1);
    gie_set <= 1'b0;
    irq(10'h080);
    repeat (6) @(posedge aclk);
    rd(pdm_pkg::STATUS_OFF, {29'h0, pdm_pkg::PDM_STOP_LO_ON}, pdm_pkg::RESP_OKAY);
    gie_set <= 1'b1;
    wake();
    chk("stab", {31'h0, n_cyc > STAB}, 32'h1);
    chk("pulse", {31'h0, pulse_seen}, 32'h1);
    chk("wake_src", {22'h0, wake_src}, 32'h080);
    rd(pdm_pkg::PWR_MODE_OFF, 32'h0, pdm_pkg::RESP_OKAY);
    rd(pdm_pkg::SYSCLK_OFF, 32'h80, pdm_pkg::RESP_OKAY);
    // Stop with low oscillator off, sub-clock and external clocks set
    wr(pdm_pkg::SYSCLK_OFF, 32'h01, pdm_pkg::RESP_OKAY);
    wr(pdm_pkg::PERIPH_OFF, 32'h0f, pdm_pkg::RESP_OKAY);
    wr(pdm_pkg::PWR_MODE_OFF, 32'h03, pdm_pkg::RESP_OKAY);
    rd(pdm_pkg::STATUS_OFF, {29'h0, pdm_pkg::PDM_STOP_LO_OFF}, pdm_pkg::RESP_OKAY);
    chk("gates", {22'h0, gates}, 32'h03f);
    irq(10'h080);
    repeat (6) @(posedge aclk);
    rd(pdm_pkg::STATUS_OFF, {29'h0, pdm_pkg::PDM_STOP_LO_OFF}, pdm_pkg::RESP_OKAY);
    irq(10'h040);
    wake();
    chk("wake_src", {22'h0, wake_src}, 32'h040);
    rd(pdm_pkg::PWR_MODE_OFF, 32'h0, pdm_pkg::RESP_OKAY);
    // Reset in the middle of stop brings every register back
    wr(pdm_pkg::PWR_MODE_OFF, 32'h03, pdm_pkg::RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 8'h87; i <= 8'h8b; i++) rd(i[7:0], 32'h0, pdm_pkg::RESP_OKAY);
    chk("gates", {22'h0, gates}, 32'h3fe);
    stop_test();
  end
endmodule

`default_nettype wire
